// File: inc/eic_defs.vh
// eic_defs.vh: offsets, field positions, fault codes for the enclave checker
// assumes plain verilog-2005 and inclusion by bare name
`ifndef EIC_DEFS_VH
`define EIC_DEFS_VH

// register byte offsets on apb
`define EIC_OFF_CTRL      12'h000
`define EIC_OFF_BMP_LO    12'h004
`define EIC_OFF_BMP_HI    12'h008
`define EIC_OFF_STATUS    12'h00c
`define EIC_OFF_SEG_A_LO  12'h010
`define EIC_OFF_SEG_A_HI  12'h014
`define EIC_OFF_SEG_B_LO  12'h018
`define EIC_OFF_SEG_B_HI  12'h01c
`define EIC_OFF_COUNT     12'h020

// control register bits
`define EIC_CTRL_SLEAF_EXIT  0
`define EIC_CTRL_APIC_VIRT   1
`define EIC_CTRL_EPT_EN      2
`define EIC_CTRL_RESET_VAL   32'h0000_0000

// fault codes on the verdict port
`define EIC_F_NONE      3'h0
`define EIC_F_UD        3'h1
`define EIC_F_GP        3'h2
`define EIC_F_PF        3'h3
`define EIC_F_VMEXIT    3'h4
`define EIC_F_APIC_EXIT 3'h5

// processor operating modes
`define EIC_MODE_16     2'h0
`define EIC_MODE_32     2'h1
`define EIC_MODE_64     2'h2

// instruction classes
`define EIC_OP_USER     3'h0
`define EIC_OP_SUPV     3'h1
`define EIC_OP_SEGMOD   3'h2
`define EIC_OP_WRBASE   3'h3
`define EIC_OP_FETCH    3'h4
`define EIC_OP_ACCESS   3'h5
`define EIC_OP_AEX      3'h6

// user leaf numbers
`define EIC_LEAF_ENTER  6'h02
`define EIC_LEAF_RESUME 6'h03
`define EIC_LEAF_EXIT   6'h04
// supervisor debug leaves
`define EIC_LEAF_DBGRD  6'h04
`define EIC_LEAF_DBGWR  6'h05

`endif

// File: logic/eic_enclave_checker.v
// eic_enclave_checker: checks and segment side effects of enclave
// instructions; one request per cycle, verdict one cycle later.
// assumes inputs synchronous to clk_sys_i and apb master per amba spec.
`timescale 1ns/1ps
`include "eic_defs.vh"

module eic_enclave_checker #(
  parameter AW = 64
) (
  // clock and reset
  input  wire          clk_sys_i,
  input  wire          rst_i,
  // apb slave
  input  wire          psel_i,
  input  wire          penable_i,
  input  wire          pwrite_i,
  input  wire [11:0]   paddr_i,
  input  wire [31:0]   pwdata_i,
  output wire          pready_o,
  output wire          pslverr_o,
  output reg  [31:0]   prdata_o,
  // instruction request
  input  wire          req_valid_i,
  input  wire [2:0]    req_op_i,
  input  wire [5:0]    req_leaf_i,
  input  wire          opsize_prefix_i,
  input  wire          seg_override_i,
  input  wire          addrsize_prefix_i,
  input  wire [1:0]    cpu_mode_i,
  input  wire          cs_default_i,
  input  wire [1:0]    current_privilege_level_i,
  input  wire          paging_en_i,
  input  wire          guest_i,
  input  wire          in_enclave_i,
  // segment state
  input  wire          ds_usable_i,
  input  wire          ds_expand_down_i,
  input  wire [AW-1:0] ds_base_i,
  input  wire [31:0]   ds_limit_i,
  input  wire          ds_writable_i,
  input  wire          other_seg_base_nz_i,
  // thread control and enclave control structure fields
  input  wire          long_mode_attribute_i,
  input  wire [AW-1:0] enclave_base_address_i,
  input  wire [AW-1:0] enclave_size_i,
  input  wire [AW-1:0] seg_a_base_offset_i,
  input  wire [AW-1:0] seg_b_base_offset_i,
  input  wire [31:0]   seg_a_limit_i,
  input  wire [31:0]   seg_b_limit_i,
  input  wire          tseg_writable_i,
  // current thread segments and base write data
  input  wire [AW-1:0] seg_a_base_i,
  input  wire [AW-1:0] seg_b_base_i,
  input  wire [31:0]   seg_a_limit_cur_i,
  input  wire [31:0]   seg_b_limit_cur_i,
  input  wire          wr_base_sel_b_i,
  input  wire [AW-1:0] wr_base_data_i,
  // memory access
  input  wire [AW-1:0] mem_offset_i,
  input  wire          access_implicit_i,
  input  wire          access_enclave_i,
  input  wire          apic_overlap_i,
  input  wire          apic_redirect_i,
  input  wire          access_fault_i,
  // verdict
  output reg           done_o,
  output reg  [2:0]    fault_o,
  output reg           fault_err_zero_o,
  output reg  [AW-1:0] lin_addr_o,
  output reg           set_ad_flags_o,
  output reg           set_ept_ad_o,
  output reg           seg_load_o,
  output reg  [AW-1:0] seg_a_base_o,
  output reg  [31:0]   seg_a_limit_o,
  output reg  [AW-1:0] seg_b_base_o,
  output reg  [31:0]   seg_b_limit_o
);

  ////////////////////////////////////////////////////////////////////////
  // registers

  reg [31:0]   ctrl;
  reg [63:0]   leaf_bitmap;
  reg [31:0]   fault_count;
  reg          saved_valid;
  reg [AW-1:0] saved_a_base;
  reg [AW-1:0] saved_b_base;
  reg [31:0]   saved_a_limit;
  reg [31:0]   saved_b_limit;
  // frame copy of bases written inside the enclave
  reg [AW-1:0] frame_a_base;
  reg [AW-1:0] frame_b_base;
  reg          frame_valid;

  wire sleaf_exit_en = ctrl[`EIC_CTRL_SLEAF_EXIT];
  wire apic_virt_en  = ctrl[`EIC_CTRL_APIC_VIRT];
  wire ept_en        = ctrl[`EIC_CTRL_EPT_EN];

  ////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait, unmapped reads zero with error

  wire apb_acc = psel_i & penable_i;
  wire apb_wr  = apb_acc & pwrite_i;
  reg  addr_ok;

  assign pready_o  = 1'b1;
  assign pslverr_o = apb_acc & ~addr_ok;

  always @* begin
    addr_ok  = 1'b1;
    prdata_o = 32'h0000_0000;
    case (paddr_i)
      `EIC_OFF_CTRL:     prdata_o = ctrl;
      `EIC_OFF_BMP_LO:   prdata_o = leaf_bitmap[31:0];
      `EIC_OFF_BMP_HI:   prdata_o = leaf_bitmap[63:32];
      `EIC_OFF_STATUS:   prdata_o = {29'h0, frame_valid, saved_valid,
                                     in_enclave_i};
      `EIC_OFF_SEG_A_LO: prdata_o = saved_a_base[31:0];
      `EIC_OFF_SEG_A_HI: prdata_o = saved_a_base[AW-1:32];
      `EIC_OFF_SEG_B_LO: prdata_o = saved_b_base[31:0];
      `EIC_OFF_SEG_B_HI: prdata_o = saved_b_base[AW-1:32];
      `EIC_OFF_COUNT:    prdata_o = fault_count;
      default:           addr_ok  = 1'b0;
    endcase
  end

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl        <= `EIC_CTRL_RESET_VAL;
      leaf_bitmap <= 64'h0;
    end else if (apb_wr) begin
      if (paddr_i == `EIC_OFF_CTRL)
        ctrl <= {29'h0, pwdata_i[2:0]};
      if (paddr_i == `EIC_OFF_BMP_LO)
        leaf_bitmap[31:0] <= pwdata_i;
      if (paddr_i == `EIC_OFF_BMP_HI)
        leaf_bitmap[63:32] <= pwdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address formation

  reg  [AW-1:0] next_lin;
  // 16-bit mode still uses a 32-bit address, cs default size unused
  wire          narrow = (cpu_mode_i != `EIC_MODE_64);

  always @* begin
    // override and address-size prefixes never reach this sum
    next_lin = ds_base_i + mem_offset_i;
    if (narrow)
      next_lin = {{(AW-32){1'b0}}, next_lin[31:0]};
  end

  ////////////////////////////////////////////////////////////////////////
  // thread segment candidates

  wire [AW-1:0] new_a_base = seg_a_base_offset_i + enclave_base_address_i;
  wire [AW-1:0] new_b_base = seg_b_base_offset_i + enclave_base_address_i;
  wire [AW:0]   a_end = {1'b0, new_a_base} + {{(AW-31){1'b0}}, seg_a_limit_i};
  wire [AW:0]   b_end = {1'b0, new_b_base} + {{(AW-31){1'b0}}, seg_b_limit_i};
  wire [AW:0]   ds_end = {1'b0, ds_base_i} + {{(AW-31){1'b0}}, ds_limit_i};
  // subset of data segment range and rights
  wire tseg_ok = (new_a_base >= ds_base_i) && (a_end <= ds_end) &&
                 (new_b_base >= ds_base_i) && (b_end <= ds_end) &&
                 (ds_writable_i | ~tseg_writable_i);

  wire [AW-1:0] enc_top  = enclave_base_address_i + enclave_size_i;
  wire          in_range = (next_lin >= enclave_base_address_i) &&
                           (next_lin < enc_top);

  ////////////////////////////////////////////////////////////////////////
  // verdict

  wire is_user  = (req_op_i == `EIC_OP_USER);
  wire is_supv  = (req_op_i == `EIC_OP_SUPV);
  wire is_leaf  = is_user | is_supv;
  wire is_enter = is_user & (req_leaf_i == `EIC_LEAF_ENTER);
  wire is_res   = is_user & (req_leaf_i == `EIC_LEAF_RESUME);
  wire is_exit  = is_user & (req_leaf_i == `EIC_LEAF_EXIT);
  wire is_dbg   = is_supv & ((req_leaf_i == `EIC_LEAF_DBGRD) |
                             (req_leaf_i == `EIC_LEAF_DBGWR));
  wire mode_ok  = long_mode_attribute_i == (cpu_mode_i == `EIC_MODE_64);

  reg [2:0] next_fault;
  reg       next_err_zero;

  always @* begin
    next_fault    = `EIC_F_NONE;
    next_err_zero = 1'b0;
    if (is_leaf) begin
      if (opsize_prefix_i)
        next_fault = `EIC_F_UD;
      else if (~paging_en_i && ~is_dbg)
        next_fault = `EIC_F_UD;
      else if (is_supv && current_privilege_level_i != 2'h0)
        next_fault = `EIC_F_GP;
      else if (is_supv && guest_i && sleaf_exit_en &&
               leaf_bitmap[req_leaf_i])
        next_fault = `EIC_F_VMEXIT;
      else if (~ds_usable_i || ds_expand_down_i) begin
        next_fault    = `EIC_F_GP;
        next_err_zero = 1'b1;
      end else if ((is_enter | is_res) &&
                   (other_seg_base_nz_i || ~tseg_ok || ~mode_ok ||
                    current_privilege_level_i != 2'h3))
        next_fault = `EIC_F_GP;
      else if (access_fault_i)
        next_fault = `EIC_F_PF;
    end else if (req_op_i == `EIC_OP_SEGMOD) begin
      if (in_enclave_i)
        next_fault = `EIC_F_UD;
    end else if (req_op_i == `EIC_OP_WRBASE) begin
      if (in_enclave_i && ~long_mode_attribute_i)
        next_fault = `EIC_F_UD;
    end else if (req_op_i == `EIC_OP_FETCH) begin
      if (in_enclave_i && ~in_range)
        next_fault = `EIC_F_GP;
    end else if (req_op_i == `EIC_OP_ACCESS) begin
      // implicit accesses skip the apic page check entirely
      if (apic_virt_en && guest_i && ~access_implicit_i) begin
        if (access_enclave_i && apic_overlap_i)
          next_fault = `EIC_F_PF;
        else if (~access_enclave_i && apic_redirect_i)
          next_fault = `EIC_F_APIC_EXIT;
      end
      if (next_fault == `EIC_F_NONE && access_fault_i)
        next_fault = `EIC_F_PF;
    end
  end

  // flags of a clean access stand even if the instruction faults later
  wire good_acc = req_valid_i & ~access_fault_i &
                  ~(apic_virt_en & guest_i & ~access_implicit_i &
                    (apic_overlap_i | apic_redirect_i));

  wire accept = req_valid_i & (next_fault == `EIC_F_NONE);

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      done_o           <= 1'b0;
      fault_o          <= `EIC_F_NONE;
      fault_err_zero_o <= 1'b0;
      lin_addr_o       <= {AW{1'b0}};
      set_ad_flags_o   <= 1'b0;
      set_ept_ad_o     <= 1'b0;
      seg_load_o       <= 1'b0;
      seg_a_base_o     <= {AW{1'b0}};
      seg_a_limit_o    <= 32'h0;
      seg_b_base_o     <= {AW{1'b0}};
      seg_b_limit_o    <= 32'h0;
      saved_valid      <= 1'b0;
      saved_a_base     <= {AW{1'b0}};
      saved_b_base     <= {AW{1'b0}};
      saved_a_limit    <= 32'h0;
      saved_b_limit    <= 32'h0;
      frame_valid      <= 1'b0;
      frame_a_base     <= {AW{1'b0}};
      frame_b_base     <= {AW{1'b0}};
      fault_count      <= 32'h0;
    end else begin
      done_o           <= req_valid_i;
      fault_o          <= req_valid_i ? next_fault : `EIC_F_NONE;
      fault_err_zero_o <= req_valid_i & next_err_zero;
      lin_addr_o       <= next_lin;
      set_ad_flags_o   <= good_acc;
      set_ept_ad_o     <= good_acc & ept_en;
      seg_load_o       <= 1'b0;
      if (req_valid_i && next_fault != `EIC_F_NONE)
        fault_count <= fault_count + 32'h1;
      if (accept && (is_enter || is_res)) begin
        saved_valid   <= 1'b1;
        saved_a_base  <= seg_a_base_i;
        saved_b_base  <= seg_b_base_i;
        saved_a_limit <= seg_a_limit_cur_i;
        saved_b_limit <= seg_b_limit_cur_i;
        seg_load_o    <= 1'b1;
        seg_a_limit_o <= seg_a_limit_i;
        seg_b_limit_o <= seg_b_limit_i;
        if (is_res && frame_valid) begin
          seg_a_base_o <= frame_a_base;
          seg_b_base_o <= frame_b_base;
          frame_valid  <= 1'b0;
        end else begin
          seg_a_base_o <= new_a_base;
          seg_b_base_o <= new_b_base;
        end
      end else if (req_valid_i && saved_valid &&
                   (is_exit && accept ||
                    req_op_i == `EIC_OP_AEX)) begin
        saved_valid   <= 1'b0;
        seg_load_o    <= 1'b1;
        seg_a_base_o  <= saved_a_base;
        seg_b_base_o  <= saved_b_base;
        seg_a_limit_o <= saved_a_limit;
        seg_b_limit_o <= saved_b_limit;
        if (req_op_i == `EIC_OP_AEX && long_mode_attribute_i) begin
          frame_valid  <= 1'b1;
          frame_a_base <= seg_a_base_i;
          frame_b_base <= seg_b_base_i;
        end
      end else if (accept && req_op_i == `EIC_OP_WRBASE) begin
        seg_load_o <= 1'b1;
        if (wr_base_sel_b_i)
          seg_b_base_o <= wr_base_data_i;
        else
          seg_a_base_o <= wr_base_data_i;
      end
    end
  end

endmodule // eic_enclave_checker

// File: dv/eic_enclave_checker_assertions.sv
// eic_enclave_checker_assertions: port-level checks of the enclave checker
// assumes a bind onto eic_enclave_checker, one clock, async high reset
`timescale 1ns/1ps
`include "eic_defs.vh"

module eic_chk_assertions (
  // clock, reset and apb
  input wire logic        clk_sys_i, rst_i, psel_i, penable_i, pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  // request
  input wire logic        req_valid_i, opsize_prefix_i, paging_en_i,
  input wire logic        in_enclave_i, ds_usable_i, guest_i,
  input wire logic        access_implicit_i, access_enclave_i,
  input wire logic        apic_overlap_i,
  input wire logic [2:0]  req_op_i,
  input wire logic [5:0]  req_leaf_i,
  input wire logic [1:0]  current_privilege_level_i,
  // verdict
  input wire logic        done_o, seg_load_o, fault_err_zero_o,
  input wire logic [2:0]  fault_o
);
  ////////////////////////////////////////////////////////////////////////
  // shadow of the control bits; apic checks only hold while enabled
  logic [2:0] ctrl;
  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i) ctrl <= 3'h0;
    else if (psel_i && penable_i && pwrite_i && paddr_i == `EIC_OFF_CTRL)
      ctrl <= pwdata_i[2:0];
  wire lf = req_valid_i && req_op_i <= `EIC_OP_SUPV && !opsize_prefix_i;
  wire sv = lf && req_op_i == `EIC_OP_SUPV && paging_en_i;
  wire ac = req_valid_i && req_op_i == `EIC_OP_ACCESS && ctrl[1];
  wire dbg = req_leaf_i inside {`EIC_LEAF_DBGRD, `EIC_LEAF_DBGWR};

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_opsize_ud:
    assert property (req_valid_i && req_op_i <= `EIC_OP_SUPV &&
      opsize_prefix_i |=> done_o && fault_o == `EIC_F_UD)
    else $error("operand-size prefix not refused");
  a_nopage_ud:
    assert property (lf && !paging_en_i && !(req_op_i == `EIC_OP_SUPV &&
      dbg) |=> fault_o == `EIC_F_UD) else $error("leaf ran without paging");
  a_ds_gp_zero:
    assert property (lf && paging_en_i && req_op_i == `EIC_OP_USER &&
      !ds_usable_i |=> fault_o == `EIC_F_GP && fault_err_zero_o)
    else $error("unusable data segment not refused");
  a_cpl_first:
    assert property (sv && current_privilege_level_i != 2'h0
      |=> fault_o == `EIC_F_GP) else $error("privilege check not first");
  a_no_exit_host:
    assert property (sv && (!guest_i || !ctrl[0])
      |=> fault_o != `EIC_F_VMEXIT) else $error("exit without bitmap");
  a_segmod_ud:
    assert property (req_valid_i && req_op_i == `EIC_OP_SEGMOD &&
      in_enclave_i |=> fault_o == `EIC_F_UD) else $error("segment change ok");
  a_apic_pf:
    assert property (ac && guest_i && !access_implicit_i && access_enclave_i
      && apic_overlap_i |=> fault_o == `EIC_F_PF) else $error("apic overlap");
  a_implicit_quiet:
    assert property (ac && access_implicit_i
      |=> fault_o != `EIC_F_APIC_EXIT) else $error("implicit access exited");
  a_idle_quiet:
    assert property (!req_valid_i |=> !done_o && !seg_load_o)
    else $error("verdict without request");

  c_enter: cover property (lf && req_leaf_i == `EIC_LEAF_ENTER ##1 seg_load_o);
  c_vmexit: cover property (done_o && fault_o == `EIC_F_VMEXIT);
  c_apic_exit: cover property (done_o && fault_o == `EIC_F_APIC_EXIT);
endmodule // eic_chk_assertions

bind eic_enclave_checker eic_chk_assertions u_eic_chk_assertions (.*);

// File: dv/eic_enclave_checker_tb.sv
// eic_enclave_checker_tb: self-checking bench with a reference model
// assumes apb answers in the access phase, verdict one cycle after request
`timescale 1ns/1ps
`include "eic_defs.vh"

module eic_enclave_checker_tb;
  localparam int AW = 64;
  logic clk_sys_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic req_valid_i = 0, opsize_prefix_i = 0, seg_override_i = 0;
  logic addrsize_prefix_i = 0, cs_default_i = 0, paging_en_i = 0;
  logic guest_i = 0, in_enclave_i = 0, ds_usable_i = 0, ds_expand_down_i = 0;
  logic ds_writable_i = 0, other_seg_base_nz_i = 0, tseg_writable_i = 0;
  logic long_mode_attribute_i = 0, wr_base_sel_b_i = 0, access_fault_i = 0;
  logic access_implicit_i = 0, access_enclave_i = 0, apic_overlap_i = 0;
  logic apic_redirect_i = 0;
  logic [1:0] cpu_mode_i = 0, current_privilege_level_i = 0;
  logic [2:0] req_op_i = 0, ctrl_m = 0;
  logic [5:0] req_leaf_i = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, ds_limit_i = 0, seg_a_limit_i = 0;
  logic [31:0] seg_b_limit_i = 0, seg_a_limit_cur_i = 0, seg_b_limit_cur_i = 0;
  logic [AW-1:0] ds_base_i = 0, enclave_base_address_i = 0, enclave_size_i = 0;
  logic [AW-1:0] seg_a_base_offset_i = 0, seg_b_base_offset_i = 0;
  logic [AW-1:0] seg_a_base_i = 0, seg_b_base_i = 0, wr_base_data_i = 0;
  logic [AW-1:0] mem_offset_i = 0, sa, sb, lin, bmp_m = 0;
  logic pready_o, pslverr_o, done_o, fault_err_zero_o, seg_load_o, e;
  logic set_ad_flags_o, set_ept_ad_o;
  logic [2:0] fault_o;
  logic [31:0] prdata_o, seg_a_limit_o, seg_b_limit_o, q;
  logic [AW-1:0] lin_addr_o, seg_a_base_o, seg_b_base_o;
  logic [3:0] at [4] = '{4'h6, 4'h1, 4'hf, 4'hb};
  logic [5:0] lv [6] = '{6'h04, 6'h3f, 6'h05, 6'h04, 6'h05, 6'h01};
  int n_errors = 0, num_checks = 0, cyc = 0, n_flt = 0;

  eic_enclave_checker #(.AW(AW)) u_eic_enclave_checker (.*);

  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [127:0] g, x);
    num_checks++;
    if (g !== x) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input [31:0] d);
    @(posedge clk_sys_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'h2, w, a, d};
    @(posedge clk_sys_i);
    penable_i <= 1'h1;
    do @(posedge clk_sys_i); while (pready_o !== 1'h1);
    {q, e} = {prdata_o, pslverr_o};
    {psel_i, penable_i} <= 2'h0;
    if (w && a == `EIC_OFF_CTRL) ctrl_m = d[2:0];
    if (w && a == `EIC_OFF_BMP_LO) bmp_m[31:0] = d;
    if (w && a == `EIC_OFF_BMP_HI) bmp_m[63:32] = d;
  endtask
  // k picks which entry condition is broken; 8 breaks none
  task automatic good(input int k);
    @(posedge clk_sys_i);
    {paging_en_i, opsize_prefix_i, ds_usable_i} <= {k != 1, k == 0, k != 2};
    {ds_expand_down_i, other_seg_base_nz_i} <= {k == 3, k == 4};
    current_privilege_level_i <= k == 5 ? 2'h0 : 2'h3;
    long_mode_attribute_i <= k != 6;
    ds_limit_i <= k == 7 ? 32'h0 : 32'hffff_ffff;
    {cpu_mode_i, ds_base_i, in_enclave_i} <= {`EIC_MODE_64, 65'h0};
    {ds_writable_i, tseg_writable_i} <= {1'h1, 1'($urandom)};
    {seg_a_limit_i, seg_b_limit_i} <= {32'h100, 32'h200};
    enclave_base_address_i <= 64'h1_0000;
    enclave_size_i <= 64'h10_0000;
    seg_a_base_offset_i <= $urandom % 32'h1_0000;
    seg_b_base_offset_i <= $urandom % 32'h1_0000;
    seg_a_base_i <= $urandom % 32'h1000_0000;
    seg_b_base_i <= $urandom % 32'h1000_0000;
  endtask
  function automatic logic [2:0] model();
    logic sv;
    logic ap;
    logic [AW-1:0] ln;
    sv = req_op_i == `EIC_OP_SUPV;
    ap = req_op_i == `EIC_OP_ACCESS && ctrl_m[1] && guest_i &&
         !access_implicit_i;
    ln = ds_base_i + mem_offset_i;
    if (cpu_mode_i != `EIC_MODE_64) ln[63:32] = 32'h0;
    if (req_op_i == `EIC_OP_SEGMOD)
      return in_enclave_i ? `EIC_F_UD : `EIC_F_NONE;
    if (req_op_i == `EIC_OP_WRBASE && in_enclave_i && !long_mode_attribute_i)
      return `EIC_F_UD;
    if (req_op_i == `EIC_OP_FETCH && in_enclave_i &&
        (ln < enclave_base_address_i ||
         ln >= enclave_base_address_i + enclave_size_i))
      return `EIC_F_GP;
    if (ap && access_enclave_i && apic_overlap_i) return `EIC_F_PF;
    if (ap && !access_enclave_i && apic_redirect_i)
      return `EIC_F_APIC_EXIT;
    if (req_op_i > `EIC_OP_SUPV) return `EIC_F_NONE;
    if (opsize_prefix_i) return `EIC_F_UD;
    if (!paging_en_i && !(sv && req_leaf_i inside {6'h04, 6'h05}))
      return `EIC_F_UD;
    if (sv && current_privilege_level_i != 2'h0) return `EIC_F_GP;
    if (sv && guest_i && ctrl_m[0] && bmp_m[req_leaf_i])
      return `EIC_F_VMEXIT;
    if (!ds_usable_i || ds_expand_down_i) return `EIC_F_GP;
    if (!sv && req_leaf_i inside {`EIC_LEAF_ENTER, `EIC_LEAF_RESUME} &&
        (other_seg_base_nz_i || current_privilege_level_i != 2'h3 ||
         long_mode_attribute_i != (cpu_mode_i == `EIC_MODE_64) ||
         seg_a_limit_i > ds_limit_i))
      return `EIC_F_GP;
    return `EIC_F_NONE;
  endfunction
  task automatic vreq(input logic [2:0] op, input logic [5:0] lf);
    @(posedge clk_sys_i);
    {req_valid_i, req_op_i, req_leaf_i} <= {1'h1, op, lf};
    // ignored prefixes and default size bit toggle freely
    {seg_override_i, addrsize_prefix_i, cs_default_i} <= 3'($urandom);
    @(posedge clk_sys_i);
    req_valid_i <= 1'h0;
    @(posedge clk_sys_i);
    chk(done_o, 1'h1);
    chk(fault_o, model());
    if (model() != `EIC_F_NONE) n_flt++;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    q = $urandom(32'h16e7);
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    apb(1'h0, `EIC_OFF_CTRL, 32'h0);
    chk(q, `EIC_CTRL_RESET_VAL);
    apb(1'h1, `EIC_OFF_CTRL, 32'h3);
    apb(1'h1, `EIC_OFF_BMP_LO, 32'h10);
    apb(1'h1, `EIC_OFF_BMP_HI, 32'h8000_0000);
    apb(1'h0, `EIC_OFF_BMP_HI, 32'h0);
    chk(q, 32'h8000_0000);
    apb(1'h0, 12'h100, 32'h0);
    chk({e, q}, {1'h1, 32'h0});
    for (int k = 0; k < 8; k++) begin
      good(k);
      vreq(`EIC_OP_USER, `EIC_LEAF_ENTER);
      if (k == 2) chk(fault_err_zero_o, 1'h1);
    end
    for (int j = 0; j < 2; j++) begin
      good(8);
      vreq(`EIC_OP_USER, `EIC_LEAF_ENTER);
      {sa, sb} = {seg_a_base_i, seg_b_base_i};
      chk(seg_load_o, 1'h1);
      chk(seg_a_base_o, seg_a_base_offset_i + enclave_base_address_i);
      chk(seg_b_base_o, seg_b_base_offset_i + enclave_base_address_i);
      chk({seg_a_limit_o, seg_b_limit_o}, {32'h100, 32'h200});
      @(posedge clk_sys_i);
      {in_enclave_i, wr_base_sel_b_i, wr_base_data_i} <= {2'h2, sa ^ 64'hff0};
      {seg_a_base_i, seg_b_base_i} <= {sa ^ 64'hff0, sb ^ 64'hff0};
      if (j) vreq(`EIC_OP_WRBASE, 6'h0);
      vreq(j ? `EIC_OP_AEX : `EIC_OP_USER, `EIC_LEAF_EXIT);
      chk({seg_a_base_o, seg_b_base_o}, {sa, sb});
    end
    good(8);
    vreq(`EIC_OP_USER, `EIC_LEAF_RESUME);
    chk(seg_a_base_o, sa ^ 64'hff0);
    for (int k = 0; k < 6; k++) begin
      good(k > 3 ? 1 : 8);
      @(posedge clk_sys_i);
      guest_i <= 1'h1;
      current_privilege_level_i <= k == 3 ? 2'h3 : 2'h0;
      vreq(`EIC_OP_SUPV, lv[k]);
    end
    for (int k = 0; k < 24; k++) begin
      good($urandom % 9);
      @(posedge clk_sys_i);
      {guest_i, current_privilege_level_i} <= 3'($urandom);
      vreq(3'($urandom % 2), 6'($urandom));
    end
    apb(1'h1, `EIC_OFF_CTRL, 32'h6);
    good(8);
    @(posedge clk_sys_i);
    {guest_i, current_privilege_level_i, in_enclave_i} <= 4'h9;
    vreq(`EIC_OP_SUPV, `EIC_LEAF_DBGRD);
    vreq(`EIC_OP_SEGMOD, 6'h0);
    // fetch inside then outside the enclave range, then base writes
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys_i);
      mem_offset_i <= k == 1 ? 64'h20_0000 : 64'h2_0000;
      long_mode_attribute_i <= k != 2;
      vreq(k < 2 ? `EIC_OP_FETCH : `EIC_OP_WRBASE, 6'h0);
      if (k == 3) chk(seg_a_base_o, wr_base_data_i);
    end
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys_i);
      {access_implicit_i, access_enclave_i, apic_overlap_i, apic_redirect_i}
        <= k < 4 ? at[k] : 4'h0;
      cpu_mode_i <= 2'(k % 3);
      {ds_base_i, mem_offset_i} <= {$urandom, $urandom, $urandom, $urandom};
      vreq(`EIC_OP_ACCESS, 6'h0);
      chk({set_ad_flags_o, set_ept_ad_o},
          {2{model() == `EIC_F_NONE}} & {1'h1, ctrl_m[2]});
      lin = ds_base_i + mem_offset_i;
      if (cpu_mode_i != `EIC_MODE_64) lin = {32'h0, lin[31:0]};
      if (k > 3) chk(lin_addr_o, lin);
    end
    // every refused request bumps the fault counter
    apb(1'h0, `EIC_OFF_COUNT, 32'h0);
    chk(q, n_flt);
    end_of_test();
  end
endmodule // eic_enclave_checker_tb
